/* File: pbarb_pkg.sv */
/*
  constants, types and helpers for the secondary bus port arbiter.
  assumes one clock (the bus clock) and dword configuration access with byte enables.
*/
`default_nettype none
package pbarb_pkg;

  // requesters: index 0 is the bridge, 1..6 are external pairs 0..5
  localparam int NUM_EXT = 6;
  localparam int NUM_REQ = 7;

  // register byte offsets
  localparam logic [11:0] OFF_ISOC_CTRL  = 12'h004;
  localparam logic [11:0] OFF_ARB_CTRL   = 12'h0DC;
  localparam logic [11:0] OFF_ARB_MASK   = 12'h0DD;
  localparam logic [11:0] OFF_ARB_TOSTAT = 12'h0DE;
  localparam logic [11:0] OFF_CH1_CTRL   = 12'h170;
  localparam logic [11:0] OFF_CH1_STAT   = 12'h176;
  localparam logic [11:0] OFF_TABLE_BASE = 12'h1C0;
  localparam logic [4:0]  TABLE_WORDS    = 5'h10;

  // field positions
  localparam int ARB_PARK_BIT   = 7;
  localparam int MASK_AUTO_BIT  = 6;
  localparam int MASK_TO_BIT    = 7;
  localparam int ISOC_L1_BIT    = 1;
  localparam int CH1_LOAD_BIT   = 16;
  localparam int CH1_SCHEME_LSB = 17;
  localparam int CH1_VCID_LSB   = 24;
  localparam int CH1_VCEN_BIT   = 31;
  localparam int STAT_PEND_BIT  = 16;

  // values after reset
  localparam logic [7:0] ARB_CTRL_RST = 8'h01;
  localparam logic [7:0] ARB_MASK_RST = 8'h00;
  localparam logic [2:0] ISOC_RST     = 3'h0;
  localparam logic [2:0] SCHEME_RST   = 3'h0;

  // encodings
  localparam logic [2:0] SCHEME_WRR128 = 3'h4;
  localparam logic [3:0] PORT_BRIDGE   = 4'h0;
  localparam logic [3:0] PORT_EXT_LAST = 4'h6;

  // counts of bus clocks
  localparam int          TIMEOUT_BUS_CLOCKS = 16;
  localparam logic [4:0]  TIMEOUT_CYCLES     = 5'(TIMEOUT_BUS_CLOCKS);
  localparam logic [3:0]  TB_PHASE_CYCLES    = 4'h8;

  typedef enum logic {LOAD_IDLE, LOAD_RUN} pbarb_load_e;

  // one configuration request; space 1 is the device control memory window
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        space;
    logic [11:2] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pbarb_cfg_req_s;

  // round robin: nearest requester after last, returns {found, index}
  function automatic logic [3:0] pbarb_rr_pick(input logic [6:0] req, input logic [2:0] last);
    logic [3:0] res;
    int         idx;
    res = 4'h0;
    for (int k = NUM_REQ; k >= 1; k--)
    begin
      idx = (int'(last) + k) % NUM_REQ;
      if (req[idx])
        res = {1'b1, 3'(idx)};
    end
    return res;
  endfunction : pbarb_rr_pick

endpackage : pbarb_pkg
`default_nettype wire

/* File: pbarb_table_ram.sv */
/*
  sixteen word table store with byte write enables and a registered read port.
  assumes one writer and one reader on the same clock; no reset of contents.
*/
`default_nettype none
module pbarb_table_ram
  import pbarb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        we,
  input  wire logic [3:0]  wbe,
  input  wire logic [3:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  raddr,
  output var  logic [31:0] rdata_q
);

  logic [31:0] mem [16];

  // byte lane writes
  always_ff @(posedge core_clk)
  begin
    for (int b = 0; b < 4; b++)
      if (we && wbe[b])
        mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
  end

  // read data always from a register, one edge after the address
  always_ff @(posedge core_clk)
  begin
    rdata_q <= mem[raddr];
  end

endmodule : pbarb_table_ram
`default_nettype wire

/* File: pbarb_arbiter.sv */
/*
  secondary bus grant logic: classic two-tier arbiter with parking, masks and
  time-out, 128-phase time-based arbiter, and pass-through to an outside arbiter.
  assumes request, frame and select pins are asynchronous; internal request is on core_clk.
*/
// Summary of operation
// RULE1: after reset arbitrate in classic mode, windows and second channel disabled.
// RULE2: seven requesters: bridge master plus six external request/grant pairs.
// RULE3: classic mode two tiers; reset puts bridge high, externals low.
// RULE4: park bit keeps grant on a master while nobody requests.
// RULE5: six mask bits block the matching external request; masked never granted (time-based mode grants from the unmasked raw requests).
// RULE6: time-out enabled and no response in 16 clocks records status.
// RULE7: auto mask enabled masks any master that ignores its grant (the code masks external masters only, never the bridge).
// RULE8: clearing auto mask enable drops all hardware generated masks.
// RULE9: time-out status reported per external master in the status byte.
// RULE10: time-based mode grants periodically from a 128 phase table.
// RULE11: visible and working tables; load bit copies visible into working.
// RULE12: pending bit reads one after table write until it is loaded.
// RULE13: visible table is sixteen dwords of 4-bit phase entries.
// RULE14: software gives each master at least three consecutive phases.
// RULE15: port 0 bridge, 1 to 6 external pairs 0 to 5, rest reserved.
// RULE16: software sets level-1 enable and scheme 100b for time-based mode.
// RULE17: outside select high: grant 0 is bridge request, request 0 bridge grant.
// RULE18: time-based mode steps phases cyclically, granting only that phase's requester.
`default_nettype none
module pbarb_arbiter
  import pbarb_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire pbarb_cfg_req_s   cfg_req,
  output var  logic             cfg_ack_q,
  output var  logic [31:0]      cfg_rdata_q,
  output var  logic             cfg_busy_q,
  input  wire logic             int_req,
  output var  logic             int_gnt_q,
  input  wire logic [5:0]       ext_req_n,
  output var  logic [5:0]       ext_gnt_n_q,
  input  wire logic             frame_n,
  input  wire logic             outside_arbiter_select
);

  // pin synchronisers
  logic [5:0]  req_meta_q;
  logic [5:0]  req_sync_q;
  logic        frame_meta_q;
  logic        frame_sync_q;
  logic        frame_prev_q;
  logic        sel_meta_q;
  logic        sel_sync_q;

  // registers
  logic [7:0]  arb_ctrl_q;
  logic [5:0]  sw_mask_q;
  logic        auto_en_q;
  logic        to_en_q;
  logic [5:0]  auto_mask_q;
  logic [5:0]  to_stat_q;
  logic [2:0]  isoc_q;
  logic        vc_en_q;
  logic [2:0]  vc_id_q;
  logic [2:0]  scheme_q;
  logic [7:0]  tc_map_q;
  logic        pending_q;

  // access pipeline
  logic        take;
  logic        take_wr;
  logic        acc_q;
  logic        acc_table_q;
  logic [31:0] acc_data_q;
  logic [31:0] reg_rdata;
  logic        sel_isoc;
  logic        sel_arb;
  logic        sel_ch1;
  logic        sel_ch1_stat;
  logic        sel_table;
  logic        start_load;

  // table load
  pbarb_load_e load_st_q;
  logic [4:0]  load_cnt_q;
  logic [31:0] vis_rdata;
  logic [31:0] work_rdata;
  logic [3:0]  vis_raddr;
  logic        work_we;
  logic [3:0]  work_waddr;

  // arbitration state
  logic [6:0]  phase_q;
  logic [3:0]  phase_cnt_q;
  logic        timed_mode;
  logic [3:0]  entry;
  logic        gnt_valid_q;
  logic [2:0]  owner_q;
  logic        gnt_valid_d;
  logic [2:0]  owner_d;
  logic [6:0]  cand;
  logic [6:0]  raw_req;
  logic [3:0]  pick_hi;
  logic [3:0]  pick_lo;
  logic [4:0]  to_cnt_q;
  logic        responded_q;
  logic        timeout_hit;
  logic        frame_end;

  // two flops on every pin before logic reads it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      req_meta_q   <= 6'h3F;
      req_sync_q   <= 6'h3F;
      frame_meta_q <= 1'b1;
      frame_sync_q <= 1'b1;
      frame_prev_q <= 1'b1;
      sel_meta_q   <= 1'b0;
      sel_sync_q   <= 1'b0;
    end
    else
    begin
      req_meta_q   <= ext_req_n;
      req_sync_q   <= req_meta_q;
      frame_meta_q <= frame_n;
      frame_sync_q <= frame_meta_q;
      frame_prev_q <= frame_sync_q;
      sel_meta_q   <= outside_arbiter_select;
      sel_sync_q   <= sel_meta_q;
    end
  end

  // address decode; requests are refused while a table load runs
  assign take         = (cfg_req.rd || cfg_req.wr) && !cfg_busy_q;
  assign take_wr      = take && cfg_req.wr;
  assign sel_isoc     = cfg_req.space && (cfg_req.addr == OFF_ISOC_CTRL[11:2]);
  assign sel_arb      = !cfg_req.space && (cfg_req.addr == OFF_ARB_CTRL[11:2]);
  assign sel_ch1      = !cfg_req.space && (cfg_req.addr == OFF_CH1_CTRL[11:2]);
  assign sel_ch1_stat = !cfg_req.space && (cfg_req.addr == OFF_CH1_STAT[11:2]);
  assign sel_table    = !cfg_req.space && (cfg_req.addr[11:6] == OFF_TABLE_BASE[11:6]); // RULE13
  assign start_load   = take_wr && sel_ch1 && cfg_req.be[2] && cfg_req.wdata[CH1_LOAD_BIT]; // RULE11

  // read mux for flop registers; unmapped offsets read as zero
  always_comb
  begin
    reg_rdata = 32'h0000_0000;
    if (sel_isoc)
      reg_rdata = {29'h0, isoc_q};
    else if (sel_arb)
      reg_rdata = {8'h00, 2'b00, to_stat_q, to_en_q, auto_en_q, sw_mask_q, arb_ctrl_q}; // RULE9
    else if (sel_ch1)
      reg_rdata = {vc_en_q, 4'h0, vc_id_q, 4'h0, scheme_q, 1'b0, 8'h00, tc_map_q};
    else if (sel_ch1_stat)
      reg_rdata = {15'h0, pending_q, 16'h0}; // RULE12
  end

  // configuration registers; the load bit is a trigger and reads zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      arb_ctrl_q <= ARB_CTRL_RST; // RULE3
      sw_mask_q  <= ARB_MASK_RST[5:0];
      auto_en_q  <= ARB_MASK_RST[MASK_AUTO_BIT];
      to_en_q    <= ARB_MASK_RST[MASK_TO_BIT];
      isoc_q     <= ISOC_RST; // RULE1
      vc_en_q    <= 1'b0; // RULE1
      vc_id_q    <= 3'h0;
      scheme_q   <= SCHEME_RST; // RULE1
      tc_map_q   <= 8'h00;
    end
    else if (take_wr)
    begin
      if (sel_isoc && cfg_req.be[0])
        isoc_q <= cfg_req.wdata[2:0];
      if (sel_arb && cfg_req.be[OFF_ARB_CTRL[1:0]])
        arb_ctrl_q <= cfg_req.wdata[7:0]; // RULE4
      if (sel_arb && cfg_req.be[OFF_ARB_MASK[1:0]])
      begin
        sw_mask_q <= cfg_req.wdata[13:8]; // RULE5
        auto_en_q <= cfg_req.wdata[8 + MASK_AUTO_BIT];
        to_en_q   <= cfg_req.wdata[8 + MASK_TO_BIT];
      end
      if (sel_ch1 && cfg_req.be[0])
        tc_map_q <= cfg_req.wdata[7:0];
      if (sel_ch1 && cfg_req.be[2])
        scheme_q <= cfg_req.wdata[CH1_SCHEME_LSB +: 3];
      if (sel_ch1 && cfg_req.be[3])
      begin
        vc_id_q <= cfg_req.wdata[CH1_VCID_LSB +: 3];
        vc_en_q <= cfg_req.wdata[CH1_VCEN_BIT];
      end
    end
  end

  // answer two edges after the take; table reads need the memory's extra edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      acc_q       <= 1'b0;
      acc_table_q <= 1'b0;
      acc_data_q  <= 32'h0000_0000;
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      acc_q       <= take;
      acc_table_q <= take && cfg_req.rd && sel_table;
      acc_data_q  <= (take && cfg_req.rd) ? reg_rdata : 32'h0000_0000;
      cfg_ack_q   <= acc_q;
      cfg_rdata_q <= acc_q ? (acc_table_q ? vis_rdata : acc_data_q) : cfg_rdata_q;
    end
  end

  // pending: table write sets, completed load clears; a write cannot meet a load end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pending_q <= 1'b0;
    else if (take_wr && sel_table)
      pending_q <= 1'b1; // RULE12
    else if (load_st_q == LOAD_RUN && load_cnt_q == TABLE_WORDS)
      pending_q <= 1'b0; // RULE12
  end

  // copy sequencer: read visible word n, write working word n one edge later
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      load_st_q  <= LOAD_IDLE;
      load_cnt_q <= 5'h00;
      cfg_busy_q <= 1'b0;
    end
    else
    begin
      case (load_st_q)
        LOAD_IDLE:
        begin
          if (start_load)
          begin
            load_st_q  <= LOAD_RUN; // RULE11
            load_cnt_q <= 5'h00;
            cfg_busy_q <= 1'b1;
          end
        end
        LOAD_RUN:
        begin
          load_cnt_q <= load_cnt_q + 5'h01;
          if (load_cnt_q == TABLE_WORDS)
          begin
            load_st_q  <= LOAD_IDLE;
            cfg_busy_q <= 1'b0;
          end
        end
        default:
        begin
          load_st_q  <= LOAD_IDLE;
          cfg_busy_q <= 1'b0;
        end
      endcase
    end
  end

  assign vis_raddr  = (load_st_q == LOAD_RUN) ? load_cnt_q[3:0] : cfg_req.addr[5:2];
  assign work_we    = (load_st_q == LOAD_RUN) && (load_cnt_q != 5'h00); // RULE11
  assign work_waddr = load_cnt_q[3:0] - 4'h1;

  pbarb_table_ram u_visible_table (
    .core_clk (core_clk),
    .we       (take_wr && sel_table), // RULE13
    .wbe      (cfg_req.be),
    .waddr    (cfg_req.addr[5:2]),
    .wdata    (cfg_req.wdata),
    .raddr    (vis_raddr),
    .rdata_q  (vis_rdata)
  );

  pbarb_table_ram u_working_table (
    .core_clk (core_clk),
    .we       (work_we),
    .wbe      (4'hF),
    .waddr    (work_waddr),
    .wdata    (vis_rdata),
    .raddr    (phase_q[6:3]),
    .rdata_q  (work_rdata)
  );

  // time-based mode needs both the level-1 enable and the 128 phase scheme
  assign timed_mode = isoc_q[ISOC_L1_BIT] && (scheme_q == SCHEME_WRR128); // RULE16

  // phase walk; the first cycle of a phase still shows the old word, so it grants nothing
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_q     <= 7'h00;
      phase_cnt_q <= 4'h0;
    end
    else if (!timed_mode || sel_sync_q)
    begin
      phase_q     <= 7'h00;
      phase_cnt_q <= 4'h0;
    end
    else if (phase_cnt_q == TB_PHASE_CYCLES - 4'h1)
    begin
      phase_q     <= phase_q + 7'h01; // RULE10 RULE18
      phase_cnt_q <= 4'h0;
    end
    else
      phase_cnt_q <= phase_cnt_q + 4'h1;
  end

  assign entry = work_rdata[{phase_q[2:0], 2'b00} +: 4]; // RULE13

  // candidates: bit 0 bridge, bits 1..6 external pairs 0..5
  assign raw_req     = {~req_sync_q, int_req}; // RULE2 RULE15
  assign cand        = raw_req & ~{sw_mask_q | auto_mask_q, 1'b0}; // RULE5 RULE7
  assign pick_hi     = pbarb_rr_pick(cand & arb_ctrl_q[6:0], owner_q); // RULE3
  assign pick_lo     = pbarb_rr_pick(cand & ~arb_ctrl_q[6:0], owner_q); // RULE3
  assign frame_end   = frame_sync_q && !frame_prev_q;
  assign timeout_hit = to_en_q && gnt_valid_q && (owner_q != 3'h0) && !responded_q
                       && (to_cnt_q == TIMEOUT_CYCLES); // RULE6

  // next grant; classic holds an owner until it drops, finishes or times out
  always_comb
  begin
    gnt_valid_d = gnt_valid_q;
    owner_d     = owner_q;
    if (timed_mode)
    begin
      // only the requester named by the current phase; reserved ports grant nobody
      gnt_valid_d = 1'b0;
      if (phase_cnt_q != 4'h0 && entry <= PORT_EXT_LAST && raw_req[entry[2:0]]) // RULE14 RULE15 RULE18
      begin
        gnt_valid_d = 1'b1;
        owner_d     = entry[2:0];
      end
    end
    else if (frame_sync_q && (!gnt_valid_q || !cand[owner_q] || timeout_hit || frame_end))
    begin
      if (pick_hi[3])
      begin
        gnt_valid_d = 1'b1;
        owner_d     = pick_hi[2:0];
      end
      else if (pick_lo[3])
      begin
        gnt_valid_d = 1'b1;
        owner_d     = pick_lo[2:0];
      end
      else if (arb_ctrl_q[ARB_PARK_BIT] && !timeout_hit)
      begin
        gnt_valid_d = 1'b1; // RULE4
        owner_d     = gnt_valid_q ? owner_q : PORT_BRIDGE[2:0];
      end
      else
        gnt_valid_d = 1'b0;
    end
  end

  // grant state and pins; an outside arbiter turns the pair 0 pins around
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      gnt_valid_q <= 1'b0;
      owner_q     <= 3'h0;
      int_gnt_q   <= 1'b0;
      ext_gnt_n_q <= 6'h3F;
    end
    else if (sel_sync_q)
    begin
      gnt_valid_q <= 1'b0;
      owner_q     <= 3'h0;
      int_gnt_q   <= !req_sync_q[0]; // RULE17
      ext_gnt_n_q <= {5'h1F, !int_req}; // RULE17
    end
    else
    begin
      gnt_valid_q <= gnt_valid_d;
      owner_q     <= owner_d;
      int_gnt_q   <= gnt_valid_d && (owner_d == 3'h0);
      for (int i = 0; i < NUM_EXT; i++)
        ext_gnt_n_q[i] <= !(gnt_valid_d && (owner_d == 3'(i + 1)));
    end
  end

  // response watch: idle bus clocks since grant; a seen frame sets responded_q, which blocks the time-out
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      to_cnt_q    <= 5'h00;
      responded_q <= 1'b0;
    end
    else if (!gnt_valid_q || gnt_valid_d != gnt_valid_q || owner_d != owner_q || timed_mode)
    begin
      to_cnt_q    <= 5'h00;
      responded_q <= 1'b0;
    end
    else if (!frame_sync_q)
      responded_q <= 1'b1;
    else if (cand[owner_q] && to_cnt_q != TIMEOUT_CYCLES)
      to_cnt_q <= to_cnt_q + 5'h01; // RULE6
  end

  // sticky status and automatic masks; the enables clear them
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      to_stat_q   <= 6'h00;
      auto_mask_q <= 6'h00;
    end
    else
    begin
      for (int i = 0; i < NUM_EXT; i++)
      begin
        if (timeout_hit && owner_q == 3'(i + 1))
          to_stat_q[i] <= 1'b1; // RULE6 RULE9
        else if (!to_en_q)
          to_stat_q[i] <= 1'b0;
        if (timeout_hit && auto_en_q && owner_q == 3'(i + 1))
          auto_mask_q[i] <= 1'b1; // RULE7
        else if (!auto_en_q)
          auto_mask_q[i] <= 1'b0; // RULE8
      end
    end
  end

endmodule : pbarb_arbiter
`default_nettype wire

/* File: pbarb_master_model.sv */
/*
  bridge and six outside masters facing the arbiter.
  assumes frame_n idles high.
*/
`default_nettype none
module pbarb_master_model
  import pbarb_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [6:0] want,
  input  wire logic [6:0] silent,
  input  wire logic       int_gnt_q,
  input  wire logic [5:0] ext_gnt_n_q,
  output var  logic       int_req,
  output var  logic [5:0] ext_req_n,
  output var  logic       frame_n,
  output var  int         txn [NUM_REQ]
);
  logic [6:0] gnt;
  int         left_q;

  // silent masters ask but never answer
  assign int_req   = want[0];
  assign ext_req_n = ~want[6:1];
  assign gnt       = {~ext_gnt_n_q, int_gnt_q};

  // four clocks of frame, then idle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      left_q  <= 0;
      frame_n <= 1'b1;
      txn     <= '{default: 0};
    end
    else if (left_q > 0)
    begin
      left_q  <= left_q - 1;
      frame_n <= (left_q <= 5);
    end
    else
      for (int k = 0; k < NUM_REQ; k++)
        if (gnt[k] && want[k] && !silent[k])
        begin
          left_q  <= 8;
          frame_n <= 1'b0;
          txn[k]  <= txn[k] + 1;
        end
  end
endmodule : pbarb_master_model
`default_nettype wire

/* File: pbarb_arbiter_sva.sv */
/*
  port checker for the arbiter.
  assumes a bind onto pbarb_arbiter.
*/
`default_nettype none
module pbarb_arbiter_sva
  import pbarb_pkg::*;
(
  input wire logic           core_clk,
  input wire logic           rst,
  input wire pbarb_cfg_req_s cfg_req,
  input wire logic           cfg_ack_q,
  input wire logic [31:0]    cfg_rdata_q,
  input wire logic           cfg_busy_q,
  input wire logic           int_req,
  input wire logic           int_gnt_q,
  input wire logic [5:0]     ext_gnt_n_q,
  input wire logic           outside_arbiter_select
);
  logic take;
  logic load;

  // taken requests
  assign take = (cfg_req.rd | cfg_req.wr) & ~cfg_busy_q;
  assign load = take & cfg_req.wr & ~cfg_req.space & (cfg_req.addr == OFF_CH1_CTRL[11:2])
              & cfg_req.be[2] & cfg_req.wdata[CH1_LOAD_BIT];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_busy8; cfg_busy_q [*8]; endsequence
  sequence s_busy17; s_busy8 ##1 s_busy8 ##1 cfg_busy_q; endsequence

  property p_ack_taken; take |-> ##2 cfg_ack_q; endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("no ack");
  property p_ack_cause; cfg_ack_q |-> $past(take, 2); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_rdata_hold; !cfg_ack_q |-> $stable(cfg_rdata_q); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_wr_zero; take && cfg_req.wr |-> ##2 cfg_rdata_q == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data");
  property p_load_busy; load |=> s_busy17 ##1 !cfg_busy_q; endproperty
  a_load_busy: assert property (p_load_busy) else $error("busy span");
  property p_busy_cause; $rose(cfg_busy_q) |-> $past(load); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("stray busy");
  property p_one_grant; !outside_arbiter_select [*6] |-> $onehot0({int_gnt_q, ~ext_gnt_n_q}); endproperty
  a_one_grant: assert property (p_one_grant) else $error("two grants");
  property p_outside;
    outside_arbiter_select [*4] |-> ext_gnt_n_q[5:1] == 5'h1F && ext_gnt_n_q[0] == !$past(int_req);
  endproperty
  a_outside: assert property (p_outside) else $error("pass-through");
endmodule : pbarb_arbiter_sva

bind pbarb_arbiter pbarb_arbiter_sva pbarb_arbiter_sva_i (.core_clk(core_clk), .rst(rst), .cfg_req(cfg_req),
  .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q), .cfg_busy_q(cfg_busy_q), .int_req(int_req),
  .int_gnt_q(int_gnt_q), .ext_gnt_n_q(ext_gnt_n_q), .outside_arbiter_select(outside_arbiter_select));
`default_nettype wire

/* File: tb.sv */
/*
  arbiter bench: register model and grant checks.
  assumes the package constants.
*/
`default_nettype none
module tb
  import pbarb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           core_clk, rst, sel, ack, busy, int_req, int_gnt, frame_n;
  logic [5:0]     req_n, gnt_n;
  logic [6:0]     want, silent, gv;
  logic [31:0]    rdata, rd_v;
  logic [15:0]    lfsr;
  pbarb_cfg_req_s cfg_req;
  logic [31:0]    regs [int];
  int             txn [NUM_REQ];
  int             own_q [$];
  int             n_fail, n_tests, tost, pend, hits, gap, max_gap;

  assign gv = {~gnt_n, int_gnt};
  pbarb_arbiter pbarb_arbiter_i (.core_clk(core_clk), .rst(rst), .cfg_req(cfg_req), .cfg_ack_q(ack),
    .cfg_rdata_q(rdata), .cfg_busy_q(busy), .int_req(int_req), .int_gnt_q(int_gnt), .ext_req_n(req_n),
    .ext_gnt_n_q(gnt_n), .frame_n(frame_n), .outside_arbiter_select(sel));
  pbarb_master_model pbarb_master_model_i (.core_clk(core_clk), .rst(rst), .want(want), .silent(silent),
    .int_gnt_q(int_gnt), .ext_gnt_n_q(gnt_n), .int_req(int_req), .ext_req_n(req_n), .frame_n(frame_n),
    .txn(txn));

  // 100 MHz bus clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // writable bits; status kept in tost and pend
  function automatic logic [31:0] rw_mask(input logic sp, input logic [11:0] a);
    if (sp)
      return (a == OFF_ISOC_CTRL) ? 32'h0000_0007 : 32'h0;
    if (a == OFF_ARB_CTRL)
      return 32'h0000_FFFF;
    if (a == OFF_CH1_CTRL)
      return 32'h870E_00FF;
    return (a >= OFF_TABLE_BASE) ? 32'hFFFF_FFFF : 32'h0;
  endfunction : rw_mask

  function automatic logic [31:0] exp_rd(input logic sp, input logic [11:0] a);
    logic [31:0] v;
    v = regs.exists({sp, a}) ? regs[{sp, a}] : 32'h0;
    if (!sp && a == OFF_ARB_CTRL)
      v[23:16] = 8'(tost);
    if (!sp && a == 12'h174)
      v[16] = pend[0];
    return v;
  endfunction : exp_rd

  // one-cycle request, bounded wait for ack
  task automatic cfg(input logic sp, input logic [11:0] a, input logic wr, input logic [3:0] be,
                     input logic [31:0] d);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rw_mask(sp, a);
    @(posedge core_clk);
    cfg_req <= '{!wr, wr, sp, a[11:2], be, d};
    @(posedge core_clk);
    cfg_req <= '0;
    for (int i = 0; i < 6 && ack !== 1'b1; i++)
      @(posedge core_clk) #1;
    chk("cfg ack", 32'h1, 32'(ack));
    rd_v = rdata;
    if (wr)
    begin
      regs[{sp, a}] = (exp_rd(sp, a) & rw_mask(sp, a) & ~m) | (d & m);
      if (a >= OFF_TABLE_BASE)
        pend = 1;
      if (!sp && a == OFF_CH1_CTRL && be[2] && d[CH1_LOAD_BIT])
        pend = 0;
    end
  endtask : cfg

  task automatic rd_chk(input logic sp, input logic [11:0] a, input logic [31:0] msk, input string what);
    cfg(sp, a, 1'b0, 4'hF, 32'h0);
    chk(what, exp_rd(sp, a) & msk, rd_v & msk);
  endtask : rd_chk

  // base taken after masters see new wishes
  task automatic run(input logic [6:0] w, input logic [6:0] s, input int n, input logic [6:0] e);
    int base [NUM_REQ];
    @(posedge core_clk);
    want <= w;
    silent <= s;
    @(posedge core_clk);
    #1;
    base = txn;
    repeat (n) @(posedge core_clk);
    for (int k = 0; k < NUM_REQ; k++)
      chk($sformatf("served %0d", k), 32'(e[k]), 32'(txn[k] > base[k]));
  endtask : run

  task automatic cnt_gnt(input int k, input int n);
    hits = 0;
    repeat (n) @(posedge core_clk) #1 hits += int'(gv[k]);
  endtask : cnt_gnt

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // run needs under 8000 clocks
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    conclude();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    sel = 1'b0;
    cfg_req = '0;
    want = 7'h00;
    silent = 7'h00;
    lfsr = 16'h0038;
    {n_fail, n_tests, tost, pend, gap, max_gap} = '0;
    regs[int'(OFF_ARB_CTRL)] = 32'(ARB_CTRL_RST);
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(0, OFF_ARB_CTRL, '1, "arb dword");
    rd_chk(0, OFF_CH1_CTRL, '1, "ch1 ctrl");
    rd_chk(1, OFF_ISOC_CTRL, '1, "isoc ctrl");
    rd_chk(0, 12'h100, '1, "unmapped");
    for (int w = 0; w < 16; w++)
    begin
      lfsr = lfsr_next(lfsr);
      cfg(0, OFF_TABLE_BASE + 12'(4 * w), 1'b1, 4'hF, {lfsr, ~lfsr});
      rd_chk(0, OFF_TABLE_BASE + 12'(4 * w), '1, "table word");
    end
    rd_chk(0, 12'h174, '1, "table pending");
    run(7'h7F, 7'h00, 200, 7'h01);
    run(7'h7E, 7'h00, 300, 7'h7E);
    run(7'h00, 7'h00, 30, 7'h00);
    cfg(0, OFF_ARB_CTRL, 1'b1, 4'h2, 32'h0000_0500);
    run(7'h7E, 7'h00, 300, 7'h74);
    cfg(0, OFF_ARB_CTRL, 1'b1, 4'h1, 32'h0000_0081);
    run(7'h10, 7'h00, 60, 7'h10);
    run(7'h00, 7'h00, 30, 7'h00);
    chk("parked", 32'h10, 32'(gv));
    cfg(0, OFF_ARB_CTRL, 1'b1, 4'h1, 32'h0000_0001);
    cnt_gnt(0, 10);
    chk("unparked", 32'h0, 32'(gv));
    cfg(0, OFF_ARB_CTRL, 1'b1, 4'h2, 32'h0000_C000);
    @(posedge core_clk);
    want <= 7'h08;
    silent <= 7'h08;
    for (int i = 0; i < 40 && gv[3] !== 1'b1; i++)
      @(posedge core_clk) #1;
    repeat (8) @(posedge core_clk);
    rd_chk(0, OFF_ARB_CTRL, 32'h00FF_0000, "status early");
    repeat (30) @(posedge core_clk);
    tost = 4;
    rd_chk(0, OFF_ARB_CTRL, 32'h00FF_0000, "status");
    cnt_gnt(3, 30);
    chk("auto masked", 32'h0, 32'(hits));
    cfg(0, OFF_ARB_CTRL, 1'b1, 4'h2, 32'h0000_8000);
    cnt_gnt(3, 40);
    chk("regranted", 32'h1, 32'(hits > 0));
    cfg(0, OFF_ARB_CTRL, 1'b1, 4'h2, 32'h0000_0000);
    tost = 0;
    for (int w = 0; w < 16; w++)
      cfg(0, OFF_TABLE_BASE + 12'(4 * w), 1'b1, 4'hF, {8{4'(w % 8)}});
    rd_chk(0, 12'h174, '1, "table pending");
    cfg(0, OFF_CH1_CTRL, 1'b1, 4'hF, 32'h0009_0000);
    @(posedge core_clk);
    cfg_req <= '{1'b1, 1'b0, 1'b0, OFF_ARB_CTRL[11:2], 4'hF, 32'h0};
    @(posedge core_clk);
    cfg_req <= '0;
    @(posedge core_clk);
    #1;
    chk("busy", 32'h1, 32'(busy));
    chk("refused ack", 32'h0, 32'(ack));
    for (int i = 0; i < 30 && busy !== 1'b0; i++)
      @(posedge core_clk);
    rd_chk(0, 12'h174, '1, "table loaded");
    cfg(1, OFF_ISOC_CTRL, 1'b1, 4'hF, 32'h0000_0002);
    @(posedge core_clk);
    want <= 7'h7F;
    silent <= 7'h00;
    // owner changes and longest idle span
    repeat (2100)
    begin
      @(posedge core_clk);
      #1;
      gap = (gv === 7'h0) ? gap + 1 : 0;
      max_gap = (gap > max_gap) ? gap : max_gap;
      for (int k = 0; k < NUM_REQ; k++)
        if (gv[k] === 1'b1 && (own_q.size() == 0 || own_q[$] != k))
          own_q.push_back(k);
    end
    chk("reserved idle", 32'h1, 32'(max_gap >= 64));
    chk("owners", 32'h1, 32'(own_q.size() >= 13));
    for (int i = 1; i < own_q.size(); i++)
      chk("phase owner", 32'((own_q[i - 1] + 1) % NUM_REQ), 32'(own_q[i]));
    @(posedge core_clk);
    silent <= 7'h7F;
    want <= 7'h03;
    sel <= 1'b1;
    cnt_gnt(0, 8);
    chk("outside grants", 32'h03, 32'(gv));
    @(posedge core_clk);
    want <= 7'h00;
    cnt_gnt(0, 8);
    chk("outside idle", 32'h00, 32'(gv));
    conclude();
  end
endmodule : tb
`default_nettype wire
